/* File: tbnm_pkg.sv */
// Purpose: shared constants, frame codes and checksum for the token bus node link
// Assumes: 50 MHz system clock on both ends
// Notes: one unit interval is 3.2 us; the link clock runs at twice that rate

package tbnm_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS = 20;
  localparam int UI_NS = 3200;
  localparam int UI_CYC = UI_NS / CLK_NS;
  localparam int HALF_CYC = UI_CYC / 2;
  localparam int QTR_CYC = UI_CYC / 4;
  localparam int RESP_NS = 597600;
  localparam int RESP_CYC_DEF = RESP_NS / CLK_NS;
  localparam int ALERT_UIS = 6;
  localparam int CHAR_UIS = 11;

  // ************************************************************
  // Character codes
  // ************************************************************
  localparam logic [7:0] CH_EOT = 8'h04;
  localparam logic [7:0] CH_ENQ = 8'h85;
  localparam logic [7:0] CH_ACK = 8'h86;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_SOH = 8'h01;

  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [9:0] REG_CTRL = 10'h000;
  localparam logic [9:0] REG_NODE = 10'h004;
  localparam logic [9:0] REG_DEST = 10'h008;
  localparam logic [9:0] REG_NEXT = 10'h00c;
  localparam logic [9:0] REG_LEN = 10'h010;
  localparam logic [9:0] REG_STAT = 10'h014;
  localparam logic [9:0] REG_MASK = 10'h018;
  localparam logic [9:0] REG_BUF = 10'h100;
  localparam int CTRL_START = 0;
  localparam int CTRL_OD = 1;
  localparam int ST_OK = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_NAK = 2;
  localparam logic [7:0] NODE_RST = 8'h01;
  localparam logic [7:0] NEXT_RST = 8'h02;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  typedef enum logic [1:0] {
    FR_TOKEN = 2'b00,
    FR_ENQ = 2'b01,
    FR_DATA = 2'b10,
    FR_REPLY = 2'b11
  } tbnm_frame_type;

  // Reflected CRC-16, one byte at a time
  function automatic logic [15:0] tbnm_crc16(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

/* File: tbnm_link_if.sv */
// Purpose: media link between the node and the transceiver side
// Assumes: bench drives strap_grounded
// Notes: resolves open-drain pulse pin and the strap pin

`timescale 1ns/1ps
interface tbnm_link_if;
  logic line_pulse_out;
  logic line_pulse_oe;
  logic line_pulse;
  logic line_clock_out;
  logic line_clock_oe;
  logic line_clock_out_strap;
  logic strap_grounded;
  logic tx_driver_enable;
  logic line_receive_in;

  // Weak pull-up on the pulse pin when released; the released clock pin reads the strap, low when grounded
  assign line_pulse = line_pulse_oe ? line_pulse_out : 1'b1;
  assign line_clock_out_strap = line_clock_oe ? line_clock_out : !strap_grounded;

  modport node (
    output line_pulse_out, line_pulse_oe, line_clock_out, line_clock_oe, tx_driver_enable,
    input line_clock_out_strap, line_receive_in
  );
  modport peer (
    input line_pulse, line_clock_out_strap,
    output line_receive_in
  );
endinterface

/* File: tbnm_node.sv */
// Purpose: token bus node media interface and packet delivery sequencer
// Assumes: Avalon-MM host access, backplane signalling only
// Notes: packet bytes held in a local buffer written by the host
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.

`timescale 1ns/1ps
module tbnm_node
  import tbnm_pkg::*;
#(
  parameter int RESP_CYC = RESP_CYC_DEF,
  parameter int BUF_DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic host_interrupt_n,
  // Media link
  tbnm_link_if.node link
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int TW = $clog2(RESP_CYC + 1);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ENQ = 3'b001,
    S_WRESP = 3'b010,
    S_DATA = 3'b011,
    S_WACK = 3'b100,
    S_PASS = 3'b101
  } tbnm_seq_type;

  logic [7:0] buf_mem [BUF_DEPTH];
  logic wq_q, wq_d, irq_q, irq_d, pend_q, pend_d, od_q, od_d;
  logic [31:0] rd_q, rd_d, rmux;
  logic [7:0] node_q, node_d, did_q, did_d, next_q, next_d, len_q, len_d;
  logic [2:0] stat_q, stat_d, mask_q, mask_d;
  logic wr_en, st_ok, st_fail, st_nak, clr_pend;
  logic [7:0] ui_q, ui_d;
  logic ui_tick, lclk_q, lclk_d, pulse_q, pulse_d, poe_q, poe_d, txen_q, txen_d;
  logic stp_s1, stp_s2, stp_hi_q, stp_hi_d, stp_ok_q, stp_ok_d;
  logic [1:0] stp_cnt_q, stp_cnt_d;
  logic tx_busy_q, tx_busy_d, tx_mark_q, tx_mark_d, tx_go, tx_done;
  logic [2:0] tx_al_q, tx_al_d;
  logic [3:0] tx_bits_q, tx_bits_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [7:0] tx_idx_q, tx_idx_d, tx_byte, tx_tot;
  logic [15:0] crc_q, crc_d;
  tbnm_frame_type kind_q, kind_d, go_kind;
  logic rx_s1, rx_s2, rx_on_q, rx_on_d, fr_end;
  logic [7:0] rx_cnt_q, rx_cnt_d, rx_sh_q, rx_sh_d, rx_n_q, rx_n_d;
  logic [7:0] rx_first_q, rx_first_d, rx_id_q, rx_id_d;
  logic [2:0] rx_al_q, rx_al_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic tok_ev, ack_ev, nak_ev;
  tbnm_seq_type st_q, st_d;
  logic [TW-1:0] tmr_q, tmr_d;

  assign avs_readdata = rd_q;
  assign avs_waitrequest = wq_q;
  assign host_interrupt_n = irq_q;
  assign link.line_clock_out = lclk_q;
  assign link.line_clock_oe = stp_ok_q;
  assign link.line_pulse_out = pulse_q;
  assign link.line_pulse_oe = poe_q;
  assign link.tx_driver_enable = txen_q;

  // ************************************************************
  // Host registers
  // ************************************************************
  assign wr_en = avs_write && !wq_q;

  always_comb begin
    rmux = 32'h0000_0000;
    if (avs_address[9:8] == REG_BUF[9:8]) begin
      rmux = {24'h00_0000, buf_mem[avs_address[AW+1:2]]};
    end else begin
      case (avs_address)
        REG_CTRL: rmux = {24'h00_0000, st_q, stp_hi_q, 1'b0, 1'b0, od_q, pend_q};
        REG_NODE: rmux = {24'h00_0000, node_q};
        REG_DEST: rmux = {24'h00_0000, did_q};
        REG_NEXT: rmux = {24'h00_0000, next_q};
        REG_LEN: rmux = {24'h00_0000, len_q};
        REG_STAT: rmux = {29'h0000_0000, stat_q};
        REG_MASK: rmux = {29'h0000_0000, mask_q};
        default: rmux = 32'h0000_0000;
      endcase
    end
    wq_d = !((avs_read || avs_write) && wq_q);
    rd_d = (avs_read && wq_q) ? rmux : rd_q;
    node_d = (wr_en && avs_address == REG_NODE) ? avs_writedata[7:0] : node_q;
    did_d = (wr_en && avs_address == REG_DEST) ? avs_writedata[7:0] : did_q;
    next_d = (wr_en && avs_address == REG_NEXT) ? avs_writedata[7:0] : next_q;
    len_d = (wr_en && avs_address == REG_LEN) ? avs_writedata[7:0] : len_q;
    mask_d = (wr_en && avs_address == REG_MASK) ? avs_writedata[2:0] : mask_q;
    od_d = (wr_en && avs_address == REG_CTRL) ? avs_writedata[CTRL_OD] : od_q;
    pend_d = (pend_q && !clr_pend) || (wr_en && avs_address == REG_CTRL && avs_writedata[CTRL_START]);
    stat_d = stat_q & ~((wr_en && avs_address == REG_STAT) ? avs_writedata[2:0] : 3'b000);
    stat_d = stat_d | {st_nak, st_fail, st_ok};
    irq_d = !(|(stat_q & mask_q));
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wq_q <= 1'b1;
      rd_q <= 32'h0000_0000;
      node_q <= NODE_RST;
      did_q <= 8'h00;
      next_q <= NEXT_RST;
      len_q <= 8'h00;
      mask_q <= 3'b000;
      od_q <= 1'b0;
      pend_q <= 1'b0;
      stat_q <= 3'b000;
      irq_q <= 1'b1;
    end else begin
      wq_q <= wq_d;
      rd_q <= rd_d;
      node_q <= node_d;
      did_q <= did_d;
      next_q <= next_d;
      len_q <= len_d;
      mask_q <= mask_d;
      od_q <= od_d;
      pend_q <= pend_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && avs_address[9:8] == REG_BUF[9:8]) begin
      buf_mem[avs_address[AW+1:2]] <= avs_writedata[7:0];
    end
  end

  // ************************************************************
  // Line timing, strap and pin drive
  // ************************************************************
  assign ui_tick = (ui_q == 8'(UI_CYC - 1));

  always_comb begin
    ui_d = ui_tick ? 8'h00 : ui_q + 8'h01;
    lclk_d = (ui_q < 8'(QTR_CYC)) || (ui_q >= 8'(HALF_CYC) && ui_q < 8'(HALF_CYC + QTR_CYC));
    // backplane mark is a low half-interval pulse
    pulse_d = !(tx_mark_q && ui_q < 8'(HALF_CYC));
    poe_d = !od_q || !pulse_d;
    stp_cnt_d = stp_ok_q ? stp_cnt_q : stp_cnt_q + 2'd1;
    stp_ok_d = stp_ok_q || (stp_cnt_q == 2'd2);
    stp_hi_d = (!stp_ok_q && stp_cnt_q == 2'd2) ? !stp_s2 : stp_hi_q;
    txen_d = stp_hi_q ? tx_busy_q : !tx_busy_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ui_q <= 8'h00;
      lclk_q <= 1'b0;
      pulse_q <= 1'b1;
      poe_q <= 1'b0;
      stp_s1 <= 1'b1;
      stp_s2 <= 1'b1;
      stp_cnt_q <= 2'd0;
      stp_ok_q <= 1'b0;
      stp_hi_q <= 1'b0;
      txen_q <= 1'b1;
    end else begin
      ui_q <= ui_d;
      lclk_q <= lclk_d;
      pulse_q <= pulse_d;
      poe_q <= poe_d;
      stp_s1 <= link.line_clock_out_strap;
      stp_s2 <= stp_s1;
      stp_cnt_q <= stp_cnt_d;
      stp_ok_q <= stp_ok_d;
      stp_hi_q <= stp_hi_d;
      txen_q <= txen_d;
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  always_comb begin
    tx_tot = (kind_q == FR_DATA) ? len_q + 8'd6 : 8'd3;
    tx_byte = crc_q[15:8];
    unique case (kind_q)
      FR_TOKEN: tx_byte = (tx_idx_q == 8'd0) ? CH_EOT : next_q;
      FR_ENQ: tx_byte = (tx_idx_q == 8'd0) ? CH_ENQ : did_q;
      FR_DATA: begin
        if (tx_idx_q == 8'd0) tx_byte = CH_SOH;
        else if (tx_idx_q < 8'd3) tx_byte = did_q;
        else if (tx_idx_q == 8'd3) tx_byte = len_q;
        else if (tx_idx_q < len_q + 8'd4) tx_byte = buf_mem[AW'(tx_idx_q - 8'd4)];
        else if (tx_idx_q == len_q + 8'd4) tx_byte = crc_q[7:0];
      end
      FR_REPLY: tx_byte = 8'h00;
    endcase
    {tx_busy_d, tx_mark_d, tx_al_d, tx_bits_d} = {tx_busy_q, tx_mark_q, tx_al_q, tx_bits_q};
    {tx_sh_d, tx_idx_d, crc_d} = {tx_sh_q, tx_idx_q, crc_q};
    kind_d = kind_q;
    tx_done = 1'b0;
    if (tx_go) begin
      tx_busy_d = 1'b1;
      tx_al_d = 3'(ALERT_UIS);
      tx_bits_d = 4'd0;
      tx_idx_d = 8'd0;
      crc_d = CRC_INIT;
      kind_d = go_kind;
    end else if (tx_busy_q && ui_tick) begin
      if (tx_al_q != 3'd0) begin
        tx_mark_d = 1'b1;
        tx_al_d = tx_al_q - 3'd1;
      end else if (tx_bits_q != 4'd0) begin
        tx_mark_d = tx_sh_q[0];
        tx_sh_d = {1'b0, tx_sh_q[9:1]};
        tx_bits_d = tx_bits_q - 4'd1;
      end else if (tx_idx_q < tx_tot) begin
        tx_mark_d = 1'b1;
        tx_sh_d = {tx_byte, 1'b0, 1'b1};
        tx_bits_d = 4'(CHAR_UIS - 1);
        tx_idx_d = tx_idx_q + 8'd1;
        if (kind_q == FR_DATA && tx_idx_q >= 8'd3 && tx_idx_q < len_q + 8'd4) begin
          crc_d = tbnm_crc16(crc_q, tx_byte);
        end
      end else begin
        tx_mark_d = 1'b0;
        tx_busy_d = 1'b0;
        tx_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      {tx_busy_q, tx_mark_q, tx_al_q, tx_bits_q} <= '0;
      {tx_sh_q, tx_idx_q, crc_q} <= '0;
      kind_q <= FR_TOKEN;
    end else begin
      {tx_busy_q, tx_mark_q, tx_al_q, tx_bits_q} <= {tx_busy_d, tx_mark_d, tx_al_d, tx_bits_d};
      {tx_sh_q, tx_idx_q, crc_q} <= {tx_sh_d, tx_idx_d, crc_d};
      kind_q <= kind_d;
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  always_comb begin
    {rx_on_d, rx_cnt_d, rx_sh_d, rx_n_d} = {rx_on_q, rx_cnt_q, rx_sh_q, rx_n_q};
    {rx_first_d, rx_id_d, rx_al_d, rx_bit_d} = {rx_first_q, rx_id_q, rx_al_q, rx_bit_q};
    fr_end = 1'b0;
    if (!rx_on_q) begin
      if (rx_s2) begin
        rx_on_d = 1'b1;
        rx_cnt_d = 8'(HALF_CYC - 1);
        rx_al_d = 3'd0;
        rx_bit_d = 4'd0;
        rx_n_d = 8'd0;
      end
    end else if (rx_cnt_q != 8'd0) begin
      rx_cnt_d = rx_cnt_q - 8'd1;
    end else begin
      rx_cnt_d = 8'(UI_CYC - 1);
      if (rx_al_q != 3'(ALERT_UIS)) begin
        if (rx_s2) rx_al_d = rx_al_q + 3'd1;
        else rx_on_d = 1'b0;
      end else if (rx_bit_q == 4'd0 && !rx_s2) begin
        rx_on_d = 1'b0;
        fr_end = 1'b1;
      end else begin
        rx_sh_d = {rx_s2, rx_sh_q[7:1]};
        rx_bit_d = rx_bit_q + 4'd1;
        if (rx_bit_q == 4'(CHAR_UIS - 1)) begin
          rx_bit_d = 4'd0;
          rx_n_d = rx_n_q + 8'd1;
          if (rx_n_q == 8'd0) rx_first_d = rx_sh_d;
          if (rx_n_q == 8'd1) rx_id_d = rx_sh_d;
        end
      end
    end
    tok_ev = fr_end && rx_n_q == 8'd3 && rx_first_q == CH_EOT && rx_id_q == node_q;
    ack_ev = fr_end && rx_n_q == 8'd1 && rx_first_q == CH_ACK;
    nak_ev = fr_end && rx_n_q == 8'd1 && rx_first_q == CH_NAK;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      {rx_s1, rx_s2, rx_on_q, rx_cnt_q, rx_sh_q, rx_n_q} <= '0;
      {rx_first_q, rx_id_q, rx_al_q, rx_bit_q} <= '0;
    end else begin
      rx_s1 <= link.line_receive_in;
      rx_s2 <= rx_s1;
      {rx_on_q, rx_cnt_q, rx_sh_q, rx_n_q} <= {rx_on_d, rx_cnt_d, rx_sh_d, rx_n_d};
      {rx_first_q, rx_id_q, rx_al_q, rx_bit_q} <= {rx_first_d, rx_id_d, rx_al_d, rx_bit_d};
    end
  end

  // ************************************************************
  // Delivery sequencer
  // ************************************************************
  always_comb begin
    st_d = st_q;
    tmr_d = (tmr_q != '0) ? tmr_q - TW'(1) : tmr_q;
    tx_go = 1'b0;
    go_kind = FR_TOKEN;
    {st_ok, st_fail, st_nak, clr_pend} = 4'b0000;
    unique case (st_q)
      S_IDLE: if (tok_ev) begin
        tx_go = 1'b1;
        go_kind = pend_q ? FR_ENQ : FR_TOKEN;
        st_d = pend_q ? S_ENQ : S_PASS;
      end
      S_ENQ, S_DATA: if (tx_done) begin
        tmr_d = TW'(RESP_CYC);
        st_d = (st_q == S_ENQ) ? S_WRESP : S_WACK;
      end
      S_WRESP: begin
        if (ack_ev) begin
          tx_go = 1'b1;
          go_kind = FR_DATA;
          st_d = S_DATA;
        end else if (nak_ev || tmr_q == '0) begin
          st_nak = nak_ev;
          tx_go = 1'b1;
          st_d = S_PASS;
        end
      end
      S_WACK: if (ack_ev || tmr_q == '0) begin
        st_ok = ack_ev;
        st_fail = !ack_ev;
        clr_pend = 1'b1;
        tx_go = 1'b1;
        st_d = S_PASS;
      end
      S_PASS: if (tx_done) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      tmr_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
    end
  end
endmodule

/* File: tbnm_peer.sv */
// Purpose: far-end node behind the line transceiver
// Assumes: bit timing taken from the node's doubled-rate clock pin
// Notes: answers enquiries and packets, can pass the token to the node

`timescale 1ns/1ps
module tbnm_peer
  import tbnm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // User side
  input wire logic [7:0] node_id,
  input wire logic [7:0] token_to,
  input wire logic pass_token,
  input wire logic rx_inhibit,
  output logic pkt_ok,
  output logic pkt_bad,
  output logic enq_seen,
  output logic [7:0] pkt_len,
  output logic tx_busy,
  // Media link
  tbnm_link_if.peer link
);
  logic p_s1, p_s2, c_s1, c_s2, c_prev, rise, mark, tph_q, tick;
  logic rx_on_q, rx_on_d, rx_ph_q, rx_ph_d, fr_end;
  logic [2:0] al_q, al_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, n_q, n_d, first_q, first_d, id_q, id_d, len_q, len_d;
  logic [7:0] d0_q, d0_d, d1_q, d1_d, rep_q, rep_d;
  logic [15:0] crc_q, crc_d;
  logic enq_hit, pkt_hit, good, tok_q, tok_d, ok_d, bad_d, enq_d, ok_q, bad_q, enq_q;
  logic [7:0] plen_q, plen_d;
  logic busy_q, busy_d, mk_q, mk_d;
  logic [2:0] tal_q, tal_d;
  logic [3:0] tbits_q, tbits_d;
  logic [9:0] tsh_q, tsh_d;
  logic [1:0] tidx_q, tidx_d;
  logic [7:0] tbyte;
  tbnm_frame_type tk_q, tk_d;

  assign pkt_ok = ok_q;
  assign pkt_bad = bad_q;
  assign enq_seen = enq_q;
  assign pkt_len = plen_q;
  assign tx_busy = busy_q;
  assign link.line_receive_in = mk_q;
  assign rise = c_s2 && !c_prev;
  assign mark = !p_s2;
  assign tick = rise && tph_q;

  // ************************************************************
  // Receiver
  // ************************************************************
  always_comb begin
    {rx_on_d, rx_ph_d, al_d, bit_d, sh_d, n_d} = {rx_on_q, rx_ph_q, al_q, bit_q, sh_q, n_q};
    {first_d, id_d, len_d, d0_d, d1_d, crc_d} = {first_q, id_q, len_q, d0_q, d1_q, crc_q};
    fr_end = 1'b0;
    if (rise && !rx_on_q) begin
      if (mark) begin
        {rx_on_d, rx_ph_d, al_d, bit_d, n_d, crc_d} = {1'b1, 1'b1, 3'd1, 4'd0, 8'd0, CRC_INIT};
      end
    end else if (rise && rx_ph_q) begin
      rx_ph_d = 1'b0;
    end else if (rise) begin
      rx_ph_d = 1'b1;
      if (al_q != 3'(ALERT_UIS)) begin
        if (mark) al_d = al_q + 3'd1;
        else rx_on_d = 1'b0;
      end else if (bit_q == 4'd0 && !mark) begin
        rx_on_d = 1'b0;
        fr_end = 1'b1;
      end else begin
        sh_d = {mark, sh_q[7:1]};
        bit_d = bit_q + 4'd1;
        if (bit_q == 4'(CHAR_UIS - 1)) begin
          bit_d = 4'd0;
          n_d = n_q + 8'd1;
          if (n_q == 8'd0) first_d = sh_d;
          if (n_q == 8'd1) id_d = sh_d;
          if (n_q == 8'd3) len_d = sh_d;
          if (n_q >= 8'd3) {d1_d, d0_d} = {d0_q, sh_d};
          if (n_q >= 8'd5) crc_d = tbnm_crc16(crc_q, d1_q);
        end
      end
    end
    enq_hit = fr_end && n_q == 8'd3 && first_q == CH_ENQ && id_q == node_id;
    pkt_hit = fr_end && first_q == CH_SOH && id_q == node_id;
    good = n_q >= 8'd6 && n_q == len_q + 8'd6 && crc_q == {d0_q, d1_q};
    rep_d = enq_hit ? (rx_inhibit ? CH_NAK : CH_ACK) : rep_q;
    if (pkt_hit && good) rep_d = CH_ACK;
    ok_d = pkt_hit && good;
    bad_d = pkt_hit && !good;
    enq_d = enq_hit;
    plen_d = ok_d ? len_q : plen_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      {p_s1, p_s2, c_s1, c_s2, c_prev, tph_q} <= 6'b110000;
      {rx_on_q, rx_ph_q, al_q, bit_q, sh_q, n_q} <= '0;
      {first_q, id_q, len_q, d0_q, d1_q, crc_q} <= '0;
      {ok_q, bad_q, enq_q, plen_q} <= '0;
    end else begin
      p_s1 <= link.line_pulse;
      p_s2 <= p_s1;
      c_s1 <= link.line_clock_out_strap;
      c_s2 <= c_s1;
      c_prev <= c_s2;
      tph_q <= rise ? !tph_q : tph_q;
      {rx_on_q, rx_ph_q, al_q, bit_q, sh_q, n_q} <= {rx_on_d, rx_ph_d, al_d, bit_d, sh_d, n_d};
      {first_q, id_q, len_q, d0_q, d1_q, crc_q} <= {first_d, id_d, len_d, d0_d, d1_d, crc_d};
      {ok_q, bad_q, enq_q, plen_q} <= {ok_d, bad_d, enq_d, plen_d};
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  always_comb begin
    {busy_d, mk_d, tal_d, tbits_d, tsh_d, tidx_d} =
      {busy_q, mk_q, tal_q, tbits_q, tsh_q, tidx_q};
    tk_d = tk_q;
    tok_d = tok_q || pass_token;
    tbyte = (tk_q == FR_REPLY) ? tsh_q[9:2] : ((tidx_q == 2'd0) ? CH_EOT : token_to);
    if (!busy_q && (rep_q != 8'h00 || tok_q)) begin
      busy_d = 1'b1;
      {tal_d, tbits_d, tidx_d} = {3'(ALERT_UIS), 4'd0, 2'd0};
      // Reply byte parked in the shifter, rep_q clears at start
      tsh_d = {rep_q, 2'b01};
      tk_d = (rep_q != 8'h00) ? FR_REPLY : FR_TOKEN;
      tok_d = (rep_q != 8'h00) ? tok_d : pass_token;
    end else if (busy_q && tick) begin
      if (tal_q != 3'd0) begin
        {mk_d, tal_d} = {1'b1, tal_q - 3'd1};
      end else if (tbits_q != 4'd0) begin
        {mk_d, tsh_d, tbits_d} = {tsh_q[0], 1'b0, tsh_q[9:1], tbits_q - 4'd1};
      end else if (tidx_q < ((tk_q == FR_REPLY) ? 2'd1 : 2'd3)) begin
        {mk_d, tsh_d, tbits_d} = {1'b1, tbyte, 1'b0, 1'b1, 4'(CHAR_UIS - 1)};
        tidx_d = tidx_q + 2'd1;
      end else begin
        {mk_d, busy_d} = 2'b00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      {busy_q, mk_q, tal_q, tbits_q, tsh_q, tidx_q, tok_q, rep_q} <= '0;
      tk_q <= FR_TOKEN;
    end else begin
      {busy_q, mk_q, tal_q, tbits_q, tsh_q, tidx_q} <=
        {busy_d, mk_d, tal_d, tbits_d, tsh_d, tidx_d};
      tk_q <= tk_d;
      tok_q <= tok_d;
      rep_q <= (!busy_q && rep_q != 8'h00) ? 8'h00 : rep_d;
    end
  end
endmodule

/* File: tbnm_assertions.sv */
// Purpose: wire checks on the node link
// Assumes: 160 clk per unit interval
// Notes: watches the interface only

`timescale 1ns/1ps
module tbnm_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link
  input wire logic line_pulse,
  input wire logic line_clock_out,
  input wire logic line_clock_oe,
  input wire logic strap_grounded,
  input wire logic tx_driver_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire act = tx_driver_enable == strap_grounded;
  property p_clk_high;
    $past(line_clock_oe) && $rose(line_clock_out) |=> line_clock_out [*8];
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high too short");
  property p_clk_per;
    $past(line_clock_oe) && $fell(line_clock_out) |-> ##40 $rose(line_clock_out);
  endproperty
  a_clk_per: assert property (p_clk_per) else $error("clock period wrong");
  property p_oe_hold;
    line_clock_oe |=> line_clock_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("clock pin released");
  property p_strap_rel;
    !line_clock_oe |-> line_pulse;
  endproperty
  a_strap_rel: assert property (p_strap_rel) else $error("pulse before strap");
  property p_mark_en;
    line_clock_oe && !line_pulse |-> act;
  endproperty
  a_mark_en: assert property (p_mark_en) else $error("mark without enable");
  property p_mark_len;
    $fell(line_pulse) |-> ##79 !line_pulse ##1 line_pulse;
  endproperty
  a_mark_len: assert property (p_mark_len) else $error("mark length wrong");
  property p_en_off;
    $fell(act) |-> line_pulse [*8];
  endproperty
  a_en_off: assert property (p_en_off) else $error("enable dropped in mark");
  property p_alert;
    line_clock_oe && $rose(act) |-> ##[1:160] $fell(line_pulse) ##160 $fell(line_pulse)
      ##160 $fell(line_pulse);
  endproperty
  a_alert: assert property (p_alert) else $error("alert burst wrong");
endmodule

/* File: tb_top.sv */
// Purpose: node to peer delivery bench
// Assumes: short response wait
// Notes: ack path then nak path

`timescale 1ns/1ps
module tb_top;
  import tbnm_pkg::*;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, pass_token = 0, rx_inh = 0;
  logic [9:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic wrq, irq_n, pkt_ok, pkt_bad, enq_seen;
  logic [7:0] pkt_len, pid = 8'h10;
  int fail_count = 0, num_checks = 0, exp_stat = 0, len, n;
  int ok_cnt = 0, bad_cnt = 0, enq_cnt = 0;
  int dq[$];
  tbnm_link_if link();
  tbnm_node #(.RESP_CYC(4000)) u_tbnm_node (.clk(clk), .rstn(rstn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wrq), .host_interrupt_n(irq_n), .link(link.node));
  tbnm_peer u_tbnm_peer (.clk(clk), .rstn(rstn), .node_id(pid), .token_to(NODE_RST),
    .pass_token(pass_token), .rx_inhibit(rx_inh), .pkt_ok(pkt_ok), .pkt_bad(pkt_bad),
    .enq_seen(enq_seen), .pkt_len(pkt_len), .tx_busy(), .link(link.peer));
  tbnm_chk u_tbnm_chk (.clk(clk), .rstn(rstn), .line_pulse(link.line_pulse),
    .line_clock_out(link.line_clock_out), .line_clock_oe(link.line_clock_oe),
    .strap_grounded(link.strap_grounded), .tx_driver_enable(link.tx_driver_enable));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    // Waitrequest and read data as they stood at the edge
    do begin
      @(posedge clk);
    end while (wrq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic token;
    @(posedge clk) pass_token <= 1'b1;
    @(posedge clk) pass_token <= 1'b0;
  endtask
  // Wait until the node lets go of the line drivers
  task automatic wait_idle;
    for (n = 0; n < 10000 && link.tx_driver_enable === link.strap_grounded; n++)
      @(negedge clk);
    if (n >= 10000) fail_count++;
  endtask
  always @(negedge clk) begin
    if (pkt_ok === 1'b1) ok_cnt++;
    if (pkt_bad === 1'b1) bad_cnt++;
    if (enq_seen === 1'b1) enq_cnt++;
  end
  initial forever #10 clk = ~clk;
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'ha281));
    link.strap_grounded <= 1'($urandom_range(1));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    len = $urandom_range(1, 8);
    bus(1'b1, REG_DEST, {24'h0, pid});
    bus(1'b1, REG_LEN, 32'(len));
    for (int i = 0; i < len; i++) begin
      dq.push_back($urandom_range(255));
      bus(1'b1, REG_BUF + 10'(4 * i), 32'(dq[i]));
    end
    bus(1'b1, REG_MASK, 32'h1);
    bus(1'b1, REG_CTRL, {30'h0, 1'($urandom_range(1)), 1'b1});
    token();
    for (n = 0; n < 60000 && pkt_ok !== 1'b1; n++) @(negedge clk);
    exp_stat = 1;
    for (n = 0; n < 20000 && irq_n !== 1'b0; n++) @(negedge clk);
    chk(32'(irq_n), 32'h0);
    chk(32'(pkt_len), 32'(len));
    bus(1'b0, REG_STAT, 32'h0);
    chk(q, 32'(exp_stat));
    foreach (dq[i]) begin
      bus(1'b0, REG_BUF + 10'(4 * i), 32'h0);
      chk(q, 32'(dq[i]));
    end
    bus(1'b1, REG_STAT, 32'h7);
    repeat (3) @(negedge clk);
    chk(32'(irq_n), 32'h1);
    wait_idle();
    @(posedge clk) rx_inh <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h1);
    token();
    exp_stat = 4;
    q = '0;
    for (n = 0; n < 30000 && q[2] !== 1'b1; n++) bus(1'b0, REG_STAT, 32'h0);
    chk(q, 32'(exp_stat));
    @(negedge clk);
    chk(32'(irq_n), 32'h1);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(32'(q[0]), 32'h1);
    bus(1'b0, 10'h020, 32'h0);
    chk(q, 32'h0);
    wait_idle();
    chk(32'(enq_cnt), 32'h2);
    chk(32'(ok_cnt), 32'h1);
    chk(32'(bad_cnt), 32'h0);
    stop_test();
  end
endmodule
